// ---- rtl/dces_defines.svh ----
// Register offsets, field positions, reset values and event codes for the context block.
// Operation
// - Each context has control and pointer registers
// - Context registers drive descriptor processing requests
// - Control register layout differs per context kind
// - Five-bit event field holds latest outcome
// - Event field takes ack code or own code
// - Low sixteen control bits may go to memory
// - Not every event code is written back
// - Async contexts accept only ack codes with the top bit set
// - Own event codes keep top bit clear
// - Isochronous contexts may synthesize ack codes
// - Isoch receive reports 02h on long packet
// - Async transmit reports 03h on missing ack
// - Transmit contexts report 04h on underrun
// - Isoch receive reports 05h on overrun
// - Any context reports 06h on descriptor error
`ifndef DCES_DEFINES_SVH
`define DCES_DEFINES_SVH
// Context indices.
`define DCES_CTX_AT 2'h0
`define DCES_CTX_AR 2'h1
`define DCES_CTX_IT 2'h2
`define DCES_CTX_IR 2'h3
// Byte offsets: control at 0x00 + 0x10*ctx, pointer at 0x04 + 0x10*ctx.
`define DCES_OFF_CTRL 4'h0
`define DCES_OFF_PTR 4'h4
`define DCES_OFF_CLR 4'h8
`define DCES_OFF_INT_STAT 8'h40
`define DCES_OFF_INT_CLR 8'h44
`define DCES_OFF_INT_EN 8'h48
// Control field positions.
`define DCES_BIT_RUN 15
`define DCES_BIT_WAKE 12
`define DCES_BIT_DEAD 11
`define DCES_BIT_ACTIVE 10
`define DCES_BIT_CME 29
`define DCES_BIT_MCM 28
`define DCES_BIT_IHDR 30
`define DCES_BIT_BFILL 31
`define DCES_EVT_LSB 0
`define DCES_SPD_LSB 5
// Reset values.
`define DCES_CTRL_RST 32'h0000_0000
`define DCES_PTR_RST 32'h0000_0000
// Controller-generated event codes.
`define DCES_EVT_NO_STATUS 5'h00
`define DCES_EVT_LONG_PACKET 5'h02
`define DCES_EVT_MISSING_ACK 5'h03
`define DCES_EVT_UNDERRUN 5'h04
`define DCES_EVT_OVERRUN 5'h05
`define DCES_EVT_DESC_READ 5'h06
`define DCES_ACK_COMPLETE 5'h11
`endif

// ---- rtl/dces_pkg.sv ----
// Types shared by the context status block.
package dces_pkg;
  // Kind of completion reported by the DMA side for one context.
  typedef enum logic [2:0] {
    DCES_DONE_ACK = 3'd0,
    DCES_DONE_LONG = 3'd1,
    DCES_DONE_MISS_ACK = 3'd2,
    DCES_DONE_UNDERRUN = 3'd3,
    DCES_DONE_OVERRUN = 3'd4,
    DCES_DONE_DESC_ERR = 3'd5
  } dces_done_t;
  // One completion report from a DMA engine.
  typedef struct packed {
    logic valid;
    logic [1:0] ctx;
    dces_done_t kind;
    logic [4:0] ack;
    logic [2:0] spd;
  } dces_done_rep_t;
  // Status write-back request toward host memory.
  typedef struct packed {
    logic valid;
    logic [1:0] ctx;
    logic [15:0] status;
  } dces_wb_t;
  // Bus slave states.
  typedef enum logic [2:0] {
    DCES_BS_IDLE = 3'b001,
    DCES_BS_WRESP = 3'b010,
    DCES_BS_RRESP = 3'b100
  } dces_bus_st_t;
endpackage

// ---- rtl/dces_context_status.sv ----
// Per-context control, pointer and event status block with an AXI4-Lite slave.
//
// The address map and the AXI4-Lite register port were decided locally.
`timescale 1ns/10ps
`include "dces_defines.svh"
module dces_context_status #(
  parameter int NCTX = 4
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // AXI4-Lite write channels.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels.
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Completion reports from the DMA engines.
  input dces_pkg::dces_done_rep_t done_rep,
  // Run requests and descriptor addresses toward the fetch engines.
  output logic [3:0] ctx_run,
  output logic [127:0] ctx_desc_ptr,
  // Status write-back toward host memory.
  output dces_pkg::dces_wb_t status_wb,
  // Interrupt output.
  output logic irq
);
  import dces_pkg::*;

  // Per-context storage, registered value and next value.
  logic [31:0] ctrl_reg [4], ctrl_next [4];
  logic [31:0] ptr_reg [4], ptr_next [4];
  // Interrupt status and enable.
  logic [3:0] int_stat_reg, int_stat_next;
  logic [3:0] int_en_reg, int_en_next;
  // Bus slave state; a captured write half is held until the other half arrives.
  dces_bus_st_t bs_reg, bs_next;
  logic aw_got_reg, aw_got_next;
  logic w_got_reg, w_got_next;
  logic [7:0] waddr_reg, waddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic [1:0] bresp_next, rresp_next;
  logic [31:0] rdata_next;
  // Outputs, registered.
  logic irq_next;
  dces_wb_t wb_next;
  // Event code chosen for the incoming report.
  logic [4:0] rep_code;
  // The report is legal for the context kind it names.
  logic rep_ok;
  // Write and read strobes for this cycle.
  logic do_write, do_read;
  // Maps a completion report to its event code; reserved codes cannot come out.
  always_comb begin
    rep_code = `DCES_EVT_NO_STATUS;
    rep_ok = 1'b0;
    case (done_rep.kind)
      DCES_DONE_ACK: begin
        // Async contexts take an ack code as delivered only when its bit 4 is set.
        // Isochronous contexts synthesize ack_complete.
        if (done_rep.ctx == `DCES_CTX_AT || done_rep.ctx == `DCES_CTX_AR) begin
          rep_code = done_rep.ack;
          rep_ok = done_rep.ack[4];
        end else begin
          rep_code = `DCES_ACK_COMPLETE;
          rep_ok = 1'b1;
        end
      end
      DCES_DONE_LONG: begin
        rep_code = `DCES_EVT_LONG_PACKET;
        rep_ok = (done_rep.ctx == `DCES_CTX_IR);
      end
      DCES_DONE_MISS_ACK: begin
        rep_code = `DCES_EVT_MISSING_ACK;
        rep_ok = (done_rep.ctx == `DCES_CTX_AT);
      end
      DCES_DONE_UNDERRUN: begin
        rep_code = `DCES_EVT_UNDERRUN;
        rep_ok = (done_rep.ctx == `DCES_CTX_AT || done_rep.ctx == `DCES_CTX_IT);
      end
      DCES_DONE_OVERRUN: begin
        rep_code = `DCES_EVT_OVERRUN;
        rep_ok = (done_rep.ctx == `DCES_CTX_IR);
      end
      DCES_DONE_DESC_ERR: begin
        rep_code = `DCES_EVT_DESC_READ;
        rep_ok = 1'b1;
      end
      default: begin
        // Unknown kinds are dropped so no reserved code reaches a field.
        rep_code = `DCES_EVT_NO_STATUS;
        rep_ok = 1'b0;
      end
    endcase
  end
  // Bus handshake: address and data are taken in either order, response after both.
  always_comb begin
    bs_next = bs_reg;
    aw_got_next = aw_got_reg;
    w_got_next = w_got_reg;
    waddr_next = waddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    do_write = 1'b0;
    do_read = 1'b0;
    case (bs_reg)
      DCES_BS_IDLE: begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_got_next = 1'b1;
          waddr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_got_next = 1'b1;
          wdata_next = s_axi_wdata;
          wstrb_next = s_axi_wstrb;
        end
        if (aw_got_reg && w_got_reg) begin
          do_write = 1'b1;
          aw_got_next = 1'b0;
          w_got_next = 1'b0;
          bs_next = DCES_BS_WRESP;
        end else if (s_axi_arvalid && s_axi_arready) begin
          do_read = 1'b1;
          bs_next = DCES_BS_RRESP;
        end
      end
      DCES_BS_WRESP: begin
        if (s_axi_bready) begin
          bs_next = DCES_BS_IDLE;
        end
      end
      DCES_BS_RRESP: begin
        if (s_axi_rready) begin
          bs_next = DCES_BS_IDLE;
        end
      end
      default: begin
        bs_next = DCES_BS_IDLE;
      end
    endcase
  end
  // Write decode and register update; hardware events win over software clears.
  always_comb begin
    logic [31:0] wmask;
    logic hit;
    wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
    hit = 1'b0;
    int_en_next = int_en_reg;
    int_stat_next = int_stat_reg;
    bresp_next = s_axi_bresp;
    for (int c = 0; c < 4; c++) begin
      ctrl_next[c] = ctrl_reg[c];
      ptr_next[c] = ptr_reg[c];
    end
    if (do_write) begin
      for (int c = 0; c < 4; c++) begin
        // Control is written per field; a one sets run, wake takes the written value.
        if (waddr_reg[7:4] == 4'(c) && waddr_reg[3:0] == `DCES_OFF_CTRL) begin
          hit = 1'b1;
          if (wmask[`DCES_BIT_RUN] && wdata_reg[`DCES_BIT_RUN]) begin
            ctrl_next[c][`DCES_BIT_RUN] = 1'b1;
          end
          if (wmask[`DCES_BIT_WAKE]) begin
            ctrl_next[c][`DCES_BIT_WAKE] = wdata_reg[`DCES_BIT_WAKE];
          end
          // Mode bits exist only for isochronous kinds.
          if (c == `DCES_CTX_IT && wmask[`DCES_BIT_CME]) begin
            ctrl_next[c][`DCES_BIT_CME] = wdata_reg[`DCES_BIT_CME];
          end
          if (c == `DCES_CTX_IR && wmask[31]) begin
            ctrl_next[c][31:28] = wdata_reg[31:28];
          end
        end
        // Writing a one to a run bit at the clear offset stops the context.
        if (waddr_reg[7:4] == 4'(c) && waddr_reg[3:0] == `DCES_OFF_CLR) begin
          hit = 1'b1;
          if (wmask[`DCES_BIT_RUN] && wdata_reg[`DCES_BIT_RUN]) begin
            ctrl_next[c][`DCES_BIT_RUN] = 1'b0;
          end
        end
        if (waddr_reg[7:4] == 4'(c) && waddr_reg[3:0] == `DCES_OFF_PTR) begin
          hit = 1'b1;
          ptr_next[c] = (ptr_reg[c] & ~wmask) | (wdata_reg & wmask);
        end
      end
      if (waddr_reg == `DCES_OFF_INT_EN) begin
        hit = 1'b1;
        int_en_next = wdata_reg[3:0];
      end
      if (waddr_reg == `DCES_OFF_INT_CLR) begin
        hit = 1'b1;
        int_stat_next = int_stat_reg & ~wdata_reg[3:0];
      end
      if (waddr_reg == `DCES_OFF_INT_STAT) begin
        hit = 1'b1;
      end
      bresp_next = hit ? 2'b00 : 2'b10;
    end
    // A completion report updates the event field; a descriptor error also sets dead and clears active.
    if (done_rep.valid && rep_ok) begin
      ctrl_next[done_rep.ctx][4:0] = rep_code;
      if (done_rep.ctx == `DCES_CTX_AR || done_rep.ctx == `DCES_CTX_IR) begin
        ctrl_next[done_rep.ctx][7:5] = done_rep.spd;
      end
      if (done_rep.kind == DCES_DONE_DESC_ERR) begin
        ctrl_next[done_rep.ctx][`DCES_BIT_DEAD] = 1'b1;
        ctrl_next[done_rep.ctx][`DCES_BIT_ACTIVE] = 1'b0;
      end
      int_stat_next[done_rep.ctx] = 1'b1;
    end
    // Active follows run unless the context died.
    for (int c = 0; c < 4; c++) begin
      ctrl_next[c][`DCES_BIT_ACTIVE] = ctrl_next[c][`DCES_BIT_RUN] &&
                                        !ctrl_next[c][`DCES_BIT_DEAD];
      if (!ctrl_next[c][`DCES_BIT_RUN]) begin
        ctrl_next[c][`DCES_BIT_DEAD] = 1'b0;
      end
    end
  end
  // Read mux; unmapped addresses answer with a slave error.
  always_comb begin
    rdata_next = s_axi_rdata;
    rresp_next = s_axi_rresp;
    if (do_read) begin
      rdata_next = 32'h0000_0000;
      rresp_next = 2'b10;
      if (s_axi_araddr[7:6] == 2'b00) begin
        if (s_axi_araddr[3:0] == `DCES_OFF_CTRL) begin
          rdata_next = ctrl_reg[s_axi_araddr[5:4]];
          rresp_next = 2'b00;
        end else if (s_axi_araddr[3:0] == `DCES_OFF_PTR) begin
          rdata_next = ptr_reg[s_axi_araddr[5:4]];
          rresp_next = 2'b00;
        end else if (s_axi_araddr[3:0] == `DCES_OFF_CLR) begin
          rresp_next = 2'b00;
        end
      end else if (s_axi_araddr == `DCES_OFF_INT_STAT) begin
        rdata_next = {28'h000_0000, int_stat_reg};
        rresp_next = 2'b00;
      end else if (s_axi_araddr == `DCES_OFF_INT_EN) begin
        rdata_next = {28'h000_0000, int_en_reg};
        rresp_next = 2'b00;
      end else if (s_axi_araddr == `DCES_OFF_INT_CLR) begin
        rresp_next = 2'b00;
      end
    end
  end
  // Write-back of low status half; every accepted report except a descriptor error goes out.
  always_comb begin
    irq_next = |(int_stat_next & int_en_next);
    wb_next = '0;
    if (done_rep.valid && rep_ok && done_rep.kind != DCES_DONE_DESC_ERR) begin
      wb_next.valid = 1'b1;
      wb_next.ctx = done_rep.ctx;
      wb_next.status = ctrl_next[done_rep.ctx][15:0];
    end
  end
  // State registers.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int c = 0; c < 4; c++) begin
        ctrl_reg[c] <= `DCES_CTRL_RST;
        ptr_reg[c] <= `DCES_PTR_RST;
      end
      int_stat_reg <= 4'h0;
      int_en_reg <= 4'h0;
      bs_reg <= DCES_BS_IDLE;
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      waddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      s_axi_bresp <= 2'b00;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
      irq <= 1'b0;
      status_wb <= '0;
    end else begin
      for (int c = 0; c < 4; c++) begin
        ctrl_reg[c] <= ctrl_next[c];
        ptr_reg[c] <= ptr_next[c];
      end
      int_stat_reg <= int_stat_next;
      int_en_reg <= int_en_next;
      bs_reg <= bs_next;
      aw_got_reg <= aw_got_next;
      w_got_reg <= w_got_next;
      waddr_reg <= waddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      s_axi_bresp <= bresp_next;
      s_axi_rdata <= rdata_next;
      s_axi_rresp <= rresp_next;
      irq <= irq_next;
      status_wb <= wb_next;
    end
  end
  // Handshake outputs are registered from the next state.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_rvalid <= 1'b0;
    end else begin
      s_axi_awready <= (bs_next == DCES_BS_IDLE) && !aw_got_next && !s_axi_awready;
      s_axi_wready <= (bs_next == DCES_BS_IDLE) && !w_got_next && !s_axi_wready;
      s_axi_arready <= (bs_next == DCES_BS_IDLE) && !aw_got_next && !w_got_next &&
                       !s_axi_arready && !do_read;
      s_axi_bvalid <= (bs_next == DCES_BS_WRESP);
      s_axi_rvalid <= (bs_next == DCES_BS_RRESP);
    end
  end
  // Run and pointer outputs feed the fetch engines.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctx_run <= 4'h0;
      ctx_desc_ptr <= '0;
    end else begin
      for (int c = 0; c < 4; c++) begin
        ctx_run[c] <= ctrl_next[c][`DCES_BIT_ACTIVE];
        ctx_desc_ptr[c*32 +: 32] <= ptr_next[c];
      end
    end
  end
  // Every property below samples on the rising clock and rests while reset is low.
  default clocking dces_cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // Accepted controller-generated codes keep the top event bit clear; refused reports are not checked.
  property p_own_code_msb;
    done_rep.valid && rep_ok && done_rep.kind != DCES_DONE_ACK
      |=> !ctrl_reg[$past(done_rep.ctx)][4];
  endproperty
  a_own_code_msb: assert property (p_own_code_msb) else $error("own code has msb set");
  // Long packet on isoch receive gives 02h.
  property p_long;
    done_rep.valid && done_rep.kind == DCES_DONE_LONG && done_rep.ctx == `DCES_CTX_IR
      |=> ctrl_reg[`DCES_CTX_IR][4:0] == `DCES_EVT_LONG_PACKET;
  endproperty
  a_long: assert property (p_long) else $error("long packet code wrong");
  // Missing ack on async transmit gives 03h.
  property p_miss;
    done_rep.valid && done_rep.kind == DCES_DONE_MISS_ACK && done_rep.ctx == `DCES_CTX_AT
      |=> ctrl_reg[`DCES_CTX_AT][4:0] == `DCES_EVT_MISSING_ACK;
  endproperty
  a_miss: assert property (p_miss) else $error("missing ack code wrong");
  // Underrun on a transmit context gives 04h.
  property p_under;
    done_rep.valid && done_rep.kind == DCES_DONE_UNDERRUN && !done_rep.ctx[0]
      |=> ctrl_reg[$past(done_rep.ctx)][4:0] == `DCES_EVT_UNDERRUN;
  endproperty
  a_under: assert property (p_under) else $error("underrun code wrong");
  // Overrun on isoch receive gives 05h.
  property p_over;
    done_rep.valid && done_rep.kind == DCES_DONE_OVERRUN && done_rep.ctx == `DCES_CTX_IR
      |=> ctrl_reg[`DCES_CTX_IR][4:0] == `DCES_EVT_OVERRUN;
  endproperty
  a_over: assert property (p_over) else $error("overrun code wrong");
  // Descriptor error gives 06h and stops the run output.
  property p_desc;
    done_rep.valid && done_rep.kind == DCES_DONE_DESC_ERR
      |=> ctrl_reg[$past(done_rep.ctx)][4:0] == `DCES_EVT_DESC_READ
          && !ctx_run[$past(done_rep.ctx)];
  endproperty
  a_desc: assert property (p_desc) else $error("descriptor error handling wrong");
  // Write-back carries the new low half of the control register.
  property p_wb;
    status_wb.valid |-> status_wb.status == ctrl_reg[status_wb.ctx][15:0];
  endproperty
  a_wb: assert property (p_wb) else $error("write-back status mismatch");
  // Ack codes with bit 4 set on async transmit pass through unchanged.
  property p_ack;
    done_rep.valid && done_rep.kind == DCES_DONE_ACK && done_rep.ctx == `DCES_CTX_AT
      && done_rep.ack[4] |=> ctrl_reg[`DCES_CTX_AT][4:0] == $past(done_rep.ack);
  endproperty
  a_ack: assert property (p_ack) else $error("ack code not stored");
  // Isochronous ack completions synthesize ack_complete.
  property p_isack;
    done_rep.valid && done_rep.kind == DCES_DONE_ACK && done_rep.ctx[1]
      |=> ctrl_reg[$past(done_rep.ctx)][4:0] == `DCES_ACK_COMPLETE;
  endproperty
  a_isack: assert property (p_isack) else $error("synthesized ack wrong");
endmodule

// ---- bench/dces_host_mem_model.sv ----
// Host memory model that stores the context status write-backs.
`timescale 1ns/10ps
module dces_host_mem_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Status write-back from the block.
  input dces_pkg::dces_wb_t status_wb,
  // What the memory holds so far.
  output logic [7:0] wb_count,
  output logic [1:0] last_ctx,
  output logic [15:0] last_status
);
  import dces_pkg::*;
  // One completion status word per context, as a descriptor would hold it.
  logic [15:0] status_mem [4];
  // Memory accepts every pulse at once, since the block offers no handshake here.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_count <= 8'h00;
      last_ctx <= 2'h0;
      last_status <= 16'h0000;
    end else if (status_wb.valid === 1'b1) begin
      // Only the low half of the control word travels to memory.
      status_mem[status_wb.ctx] <= status_wb.status;
      wb_count <= wb_count + 8'h01;
      last_ctx <= status_wb.ctx;
      last_status <= status_wb.status;
    end
  end
endmodule

// ---- bench/dces_context_status_tb.sv ----
// Self-checking bench for the context control and event status block.
`timescale 1ns/10ps
`include "dces_defines.svh"
module dces_context_status_tb;
  import dces_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, last_ctx;
  logic [31:0] rdata, rd;
  logic [3:0] ctx_run;
  logic [127:0] ctx_desc_ptr;
  logic [7:0] wb_count;
  logic [15:0] last_status;
  logic [1:0] resp;
  dces_done_rep_t done_rep = '0;
  dces_wb_t status_wb;
  int bad_count = 0;
  int compares = 0;
  logic [31:0] seed = 32'h1984_660a;
  logic [4:0] evt_exp [4];
  // The clock runs at 25 MHz.
  always #20 clk = ~clk;
  dces_context_status dut (.clk(clk), .reset_n(reset_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .done_rep(done_rep), .ctx_run(ctx_run),
    .ctx_desc_ptr(ctx_desc_ptr), .status_wb(status_wb), .irq(irq));
  dces_host_mem_model mem (.clk(clk), .reset_n(reset_n), .status_wb(status_wb),
    .wb_count(wb_count), .last_ctx(last_ctx), .last_status(last_status));
  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Compares one value; four-state equality keeps unknowns from matching.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  // A wait that runs out of cycles is counted and ends the run.
  task automatic hang(input string msg);
    bad_count++;
    $display("CHECK FAILED t=%0t timeout %s", $time, msg);
    report_and_stop();
  endtask
  // Write cycle: address and data offered together, each dropped once taken.
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge clk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (n == 200) hang("write");
  endtask
  // Read cycle: address held until taken, ready held until data arrives.
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge clk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (n == 200) hang("read");
  endtask
  // Drives one completion pulse and lets the update land.
  task automatic send(input int c, input int k, input logic [4:0] a, input logic [2:0] s);
    @(posedge clk);
    done_rep <= '{1'b1, 2'(c), dces_done_t'(k), a, s};
    @(posedge clk);
    done_rep.valid <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Returns {accepted, code} for a report of kind k on context c.
  function automatic logic [5:0] exp_evt(input int c, input int k, input logic [4:0] a);
    case (k)
      0: return (c < 2) ? {a[4], a} : {1'b1, `DCES_ACK_COMPLETE};
      1: return {c == 3, `DCES_EVT_LONG_PACKET};
      2: return {c == 0, `DCES_EVT_MISSING_ACK};
      3: return {c == 0 || c == 2, `DCES_EVT_UNDERRUN};
      4: return {c == 3, `DCES_EVT_OVERRUN};
      default: return {1'b1, `DCES_EVT_DESC_READ};
    endcase
  endfunction
  // Main sequence.
  initial begin
    logic [5:0] e;
    logic [7:0] n0;
    logic [4:0] a;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    for (int c = 0; c < 4; c++) begin
      evt_exp[c] = 5'h00;
      axi_read(8'(16 * c), rd, resp);
      chk(rd, `DCES_CTRL_RST, "ctrl reset");
      seed = lfsr(seed);
      axi_write(8'(16 * c + 4), seed, resp);
      axi_read(8'(16 * c + 4), rd, resp);
      chk(rd, seed, "pointer");
      chk(ctx_desc_ptr[c*32+:32], seed, "pointer out");
    end
    axi_read(8'h80, rd, resp);
    chk(32'(resp), 32'h0000_0002, "unmapped read");
    axi_write(8'h80, 32'h0000_0001, resp);
    chk(32'(resp), 32'h0000_0002, "unmapped write");
    axi_write(`DCES_OFF_INT_EN, 32'h0000_000f, resp);
    for (int c = 0; c < 4; c++) begin
      // Run must be on, or a descriptor error could not leave the dead flag standing.
      axi_write(8'(16 * c), 32'h0000_8000, resp);
      chk(32'(ctx_run[c]), 32'h1, "run set");
      for (int k = 0; k < 6; k++) begin
        for (int j = 0; j < ((k == 0) ? 4 : 1); j++) begin
          seed = lfsr(seed);
          a = seed[4:0];
          if (k == 0) a[4] = (j < 3);
          e = exp_evt(c, k, a);
          n0 = wb_count;
          send(c, k, a, seed[7:5]);
          if (e[5]) evt_exp[c] = e[4:0];
          chk(32'(wb_count), 32'(n0) + 32'(e[5] && k != 5), "write-back count");
          if (e[5] && k != 5) chk(32'(last_status[4:0]), 32'(e[4:0]), "memory event");
          if (e[5] && k != 5) chk(32'(last_ctx), 32'(c), "memory context");
          axi_read(8'(16 * c), rd, resp);
          chk(32'(rd[4:0]), 32'(evt_exp[c]), "event");
        end
      end
      chk(32'(rd[`DCES_BIT_DEAD]), 32'h1, "dead");
      chk(32'(ctx_run[c]), 32'h0, "run out");
    end
    chk(32'(irq), 32'h1, "irq raised");
    axi_write(`DCES_OFF_INT_CLR, 32'hffff_ffff, resp);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0, "irq cleared");
    axi_read(`DCES_OFF_INT_STAT, rd, resp);
    chk(rd, 32'h0000_0000, "status cleared");
    axi_write(`DCES_OFF_INT_EN, 32'h0000_0000, resp);
    send(2, 3, 5'h00, 3'h0);
    chk(32'(irq), 32'h0, "irq masked");
    axi_read(`DCES_OFF_INT_STAT, rd, resp);
    chk(32'(rd != 32'h0), 32'h1, "status sticky");
    report_and_stop();
  end
endmodule
